// [logic/safety_relay_consts.svh]
// Purpose: Constants of the safety relay start controller
// Assumes: 20 MHz system clock
// Notes:   Offsets, field positions, reset values and timing counts
`ifndef SAFETY_RELAY_CONSTS_SVH
`define SAFETY_RELAY_CONSTS_SVH
// Clock rate in Hz
`define CLK_HZ           20000000
// Waiting period before a rising-edge start is accepted
`define WAIT_TIME_MS     100
`define WAIT_CYC         (`WAIT_TIME_MS * (`CLK_HZ / 1000))
// Least start pulse in the monitored modes
`define START_PULSE_MS   30
`define START_PULSE_CYC  (`START_PULSE_MS * (`CLK_HZ / 1000))
// Longest allowed relay feedback disagreement
`define RELAY_CHECK_MS   20
`define RELAY_CHECK_CYC  (`RELAY_CHECK_MS * (`CLK_HZ / 1000))
// Mode selector codes
`define MODE_NEUTRAL     3'h0
`define MODE_AUTO        3'h1
`define MODE_MANUAL      3'h2
`define MODE_FALL        3'h3
`define MODE_RISE        3'h4
// Register byte offsets
`define REG_STATUS       8'h00
`define REG_IRQ_STATUS   8'h04
`define REG_IRQ_MASK     8'h08
`define REG_CTRL         8'h0c
// Event bit positions
`define IRQ_W            7
`define IRQ_SEL_CHANGE   0
`define IRQ_NEUTRAL      1
`define IRQ_ILLEGAL      2
`define IRQ_EARTH        3
`define IRQ_RELAY        4
`define IRQ_OUT_ON       5
`define IRQ_OUT_OFF      6
// Reset values
`define IRQ_MASK_RST     7'h00
`define CTRL_RST         1'h0
// Bus responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// [logic/safety_relay_pkg.sv]
// Purpose: Types of the safety relay start controller
// Assumes: Constants come from safety_relay_consts.svh
// Notes:   Types only
`default_nettype none
package safety_relay_pkg;
   // Selector code as read from the switch
   typedef logic [2:0] mode_t;
   // Controller states
   typedef enum logic [2:0] {ST_OFF, ST_WAIT, ST_ARM, ST_ON, ST_ERR} st_t;
endpackage
`default_nettype wire

// [logic/safety_relay_start_control.sv]
// Purpose: Start and enable control of a single-channel safety relay
// Assumes: Inputs synchronous to aclk; aresetn is the power-on reset
// Notes:   AXI4-Lite register slave with sticky event flags
// Function
// - Detect earth faults on start and input
// - Automatic mode: enable once input closes
// - Manual mode: enable with input and start closed
// - Falling mode: input closed, start pulse, enable
// - Falling mode: start first, enable on release
// - Rising mode: start accepted after waiting period
// - Monitored modes need a minimum start pulse
// - Selector change in operation: error, outputs open
// - After error ignore inputs until power cycle
// - Neutral selector position raises an error
// - Auxiliary contact opposite safety outputs, same instant
// - Relay open and close checked every cycle
// - Forbidden selector position latched like change
`timescale 1ns/100ps
`include "safety_relay_consts.svh"
`default_nettype none
module safety_relay_start_control #(
   parameter int unsigned WAIT_CYC  = `WAIT_CYC,        // Waiting period
   parameter int unsigned PULSE_CYC = `START_PULSE_CYC, // Least start pulse
   parameter int unsigned RELAY_CYC = `RELAY_CHECK_CYC  // Feedback allowance
) (
   // Clock, reset, enable
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic                    ce,
   // Field circuits
   input  wire logic                    input_closed,
   input  wire logic                    start_closed,
   input  wire logic                    earth_fault_input,
   input  wire logic                    earth_fault_start,
   input  wire safety_relay_pkg::mode_t mode_sel,
   input  wire logic                    relay_fb,
   // Relay drive and indication
   output logic                         safety_out,
   output logic                         aux_nc_out,
   output logic                         ready,
   output logic                         fault,
   output logic                         irq,
   // AXI4-Lite write
   input  wire logic [7:0]              awaddr,
   input  wire logic                    awvalid,
   output logic                         awready,
   input  wire logic [31:0]             wdata,
   input  wire logic [3:0]              wstrb,
   input  wire logic                    wvalid,
   output logic                         wready,
   output logic [1:0]                   bresp,
   output logic                         bvalid,
   input  wire logic                    bready,
   // AXI4-Lite read
   input  wire logic [7:0]              araddr,
   input  wire logic                    arvalid,
   output logic                         arready,
   output logic [31:0]                  rdata,
   output logic [1:0]                   rresp,
   output logic                         rvalid,
   input  wire logic                    rready
);
   import safety_relay_pkg::*;
   localparam logic [21:0] WAIT_LIM  = 22'(WAIT_CYC);
   localparam logic [21:0] PULSE_LIM = 22'(PULSE_CYC);
   localparam logic [21:0] RELAY_LIM = 22'(RELAY_CYC);
   st_t               st;           // Controller state
   st_t               next_st;      // Its next value
   mode_t             mode_q;       // Selector caught at power-up
   logic              mode_taken;   // Selector has been caught
   logic [21:0]       wait_cnt;     // Waiting period counter
   logic [21:0]       pulse_cnt;    // Start closure length
   logic [21:0]       mis_cnt;      // Relay disagreement length
   logic              soft_stop;    // Software forces outputs off
   logic [`IRQ_W-1:0] irq_status;   // Sticky events
   logic [`IRQ_W-1:0] irq_mask;     // Event enables
   logic [`IRQ_W-1:0] ev;           // Events of this cycle
   logic [7:0]        aw_addr_q;    // Held write address
   logic [31:0]       w_data_q;     // Held write data
   logic [3:0]        w_strb_q;     // Held strobes
   logic              aw_held;      // Write address taken
   logic              w_held;       // Write data taken
   logic              do_write;     // Both halves present
   logic              mismatch;     // Feedback disagrees with drive
   logic              wait_done;    // Waiting period over
   logic              pulse_done;   // Start held long enough
   logic              c_sel;        // Selector moved
   logic              c_neu;        // Selector in neutral
   logic              c_ill;        // Selector code forbidden
   logic              c_earth;      // Earth fault seen
   logic              c_relay;      // Relay failed to follow
   logic              err_now;      // Any error this cycle
   assign mismatch   = relay_fb != safety_out;
   assign wait_done  = wait_cnt >= WAIT_LIM;
   assign pulse_done = pulse_cnt >= PULSE_LIM;
   assign do_write   = aw_held && w_held && !bvalid;
   // Error causes, judged only while operating
   always_comb begin
      c_sel   = mode_sel != mode_q;
      c_neu   = mode_q == `MODE_NEUTRAL;
      c_ill   = mode_q > `MODE_RISE;
      c_earth = earth_fault_input || earth_fault_start;
      c_relay = mismatch && (mis_cnt == RELAY_LIM - 22'h1);
      err_now = mode_taken && (st != ST_ERR) &&
                (c_sel || c_neu || c_ill || c_earth || c_relay);
   end
   // Start sequencing per latched mode
   always_comb begin
      next_st = st;
      if (mode_taken && st != ST_ERR) begin
         if (err_now) begin
            next_st = ST_ERR;
         end else if (soft_stop) begin
            next_st = ST_OFF;
         end else begin
            unique case (st)
               ST_OFF: begin
                  // Welded contact keeps the unit off
                  if (!relay_fb) begin
                     if (mode_q == `MODE_AUTO && input_closed) begin
                        next_st = ST_ON;
                     end else if (mode_q == `MODE_MANUAL && input_closed && start_closed) begin
                        next_st = ST_ON;
                     end else if (mode_q == `MODE_FALL && start_closed && pulse_done) begin
                        next_st = ST_ARM;
                     end else if (mode_q == `MODE_RISE && input_closed) begin
                        next_st = ST_WAIT;
                     end
                  end
               end
               ST_WAIT: begin
                  // Start must be open when the wait ends
                  if (!input_closed) begin
                     next_st = ST_OFF;
                  end else if (wait_done && !start_closed) begin
                     next_st = ST_ARM;
                  end
               end
               ST_ARM: begin
                  if (mode_q == `MODE_FALL) begin
                     // Release decides: input closed enables
                     if (!start_closed) begin
                        next_st = input_closed ? ST_ON : ST_OFF;
                     end
                  end else if (!input_closed) begin
                     next_st = ST_OFF;
                  end else if (pulse_done) begin
                     next_st = ST_ON;
                  end
               end
               ST_ON: if (!input_closed) next_st = ST_OFF;
               ST_ERR: next_st = ST_ERR;
            endcase
         end
      end
   end
   // Selector caught once after power-up
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q     <= `MODE_NEUTRAL;
         mode_taken <= 1'b0;
      end else if (ce && !mode_taken) begin
         mode_q     <= mode_sel;
         mode_taken <= 1'b1;
      end
   end
   // State, relay drive and indication; error never leaves
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st         <= ST_OFF;
         safety_out <= 1'b0;
         aux_nc_out <= 1'b1;
         ready      <= 1'b0;
         fault      <= 1'b0;
      end else if (ce) begin
         st         <= next_st;
         safety_out <= next_st == ST_ON;
         aux_nc_out <= next_st != ST_ON;
         ready      <= mode_taken && next_st != ST_ERR;
         fault      <= next_st == ST_ERR;
      end
   end
   // Timers: waiting period, start pulse, relay feedback
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_cnt  <= 22'h0;
         pulse_cnt <= 22'h0;
         mis_cnt   <= 22'h0;
      end else if (ce) begin
         wait_cnt  <= (st != ST_WAIT) ? 22'h0 : (wait_done ? wait_cnt : wait_cnt + 22'h1);
         // Saturates so a long press stays valid
         pulse_cnt <= !start_closed ? 22'h0 : (pulse_done ? pulse_cnt : pulse_cnt + 22'h1);
         // Any agreement restarts the allowance
         mis_cnt   <= (mismatch && st != ST_ERR) ? mis_cnt + 22'h1 : 22'h0;
      end
   end
   // Events of this cycle
   always_comb begin
      ev                  = '0;
      ev[`IRQ_SEL_CHANGE] = err_now && c_sel;
      ev[`IRQ_NEUTRAL]    = err_now && c_neu;
      ev[`IRQ_ILLEGAL]    = err_now && c_ill;
      ev[`IRQ_EARTH]      = err_now && c_earth;
      ev[`IRQ_RELAY]      = err_now && c_relay;
      ev[`IRQ_OUT_ON]     = next_st == ST_ON && st != ST_ON;
      ev[`IRQ_OUT_OFF]    = next_st != ST_ON && st == ST_ON;
   end
   // Write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b1;
         wready    <= 1'b1;
         aw_held   <= 1'b0;
         w_held    <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0;
         w_strb_q  <= 4'h0;
         bvalid    <= 1'b0;
         bresp     <= `RESP_OKAY;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_addr_q <= awaddr;
            aw_held   <= 1'b1;
            awready   <= 1'b0;
         end
         if (wvalid && wready) begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
            w_held   <= 1'b1;
            wready   <= 1'b0;
         end
         if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= (aw_addr_q == `REG_STATUS || aw_addr_q == `REG_IRQ_STATUS ||
                       aw_addr_q == `REG_IRQ_MASK || aw_addr_q == `REG_CTRL) ?
                      `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end
   // Writable registers; status read-only, events win over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= '0;
         irq_mask   <= `IRQ_MASK_RST;
         soft_stop  <= `CTRL_RST;
         irq        <= 1'b0;
      end else if (ce) begin
         if (do_write && w_strb_q[0] && aw_addr_q == `REG_IRQ_STATUS) begin
            irq_status <= (irq_status & ~w_data_q[`IRQ_W-1:0]) | ev;
         end else begin
            irq_status <= irq_status | ev;
         end
         if (do_write && w_strb_q[0] && aw_addr_q == `REG_IRQ_MASK) begin
            irq_mask <= w_data_q[`IRQ_W-1:0];
         end
         if (do_write && w_strb_q[0] && aw_addr_q == `REG_CTRL) begin
            soft_stop <= w_data_q[0];
         end
         // Interrupt level, one cycle behind the flags
         irq <= |(irq_status & irq_mask);
      end
   end
   // Read channel: one read at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= `RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= `RESP_OKAY;
            unique case (araddr)
               `REG_STATUS:     rdata <= {21'h0, fault, relay_fb, start_closed,
                                          input_closed, safety_out, mode_q, st};
               `REG_IRQ_STATUS: rdata <= {25'h0, irq_status};
               `REG_IRQ_MASK:   rdata <= {25'h0, irq_mask};
               `REG_CTRL:       rdata <= {31'h0, soft_stop};
               default: begin
                  rdata <= 32'h0;
                  rresp <= `RESP_SLVERR;
               end
            endcase
         end
         if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
   a_aux_opposite: assert property (@(posedge aclk) disable iff (!aresetn)
      aux_nc_out == !safety_out) else $error("aux contact not opposite");
   a_sel_change: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && mode_taken && st != ST_ERR && mode_sel != mode_q |=> st == ST_ERR && !safety_out)
      else $error("selector change not trapped");
   a_err_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
      st == ST_ERR |=> st == ST_ERR && !safety_out && !ready) else $error("error left");
   a_neutral_err: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && mode_taken && mode_q == `MODE_NEUTRAL |=> st == ST_ERR) else $error("neutral run");
   a_illegal_err: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && mode_taken && mode_q > `MODE_RISE |=> fault) else $error("bad mode run");
   a_earth_fault: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && mode_taken && (earth_fault_input || earth_fault_start) |=> fault && !safety_out)
      else $error("earth fault missed");
   a_auto_start: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && st == ST_OFF && mode_q == `MODE_AUTO && input_closed && !relay_fb &&
      !err_now && !soft_stop |=> safety_out) else $error("auto start missed");
   a_manual_need: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(safety_out) && mode_q == `MODE_MANUAL |-> $past(start_closed) && $past(input_closed))
      else $error("manual start without both");
   a_fall_release: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(safety_out) && mode_q == `MODE_FALL |-> $past(st) == ST_ARM && !$past(start_closed))
      else $error("falling start not on release");
   a_rise_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(safety_out) && mode_q == `MODE_RISE |-> $past(pulse_done) && $past(st) == ST_ARM)
      else $error("rising start too short");
   a_wait_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      st == ST_WAIT && !wait_done |=> !safety_out) else $error("wait cut short");
   a_input_off: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && st == ST_ON && !input_closed |=> !safety_out && st != ST_ON)
      else $error("input open kept outputs");
   a_relay_chk: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && st != ST_ERR && mode_taken && c_relay |=> fault) else $error("relay fault missed");
endmodule // safety_relay_start_control
`default_nettype wire

// [dv/field_side_model.sv]
// Purpose: Field side of the relay: guard contact, start button, feedback
// Assumes: Bench commands arrive as levels synchronous to aclk
// Notes:   Feedback lags the drive by two cycles, like a slow contact
`timescale 1ns/100ps
`default_nettype none
module field_side_model (
   // Clock and relay drive
   input  wire logic aclk,
   input  wire logic safety_out,
   // Bench commands
   input  wire logic cmd_input,
   input  wire logic cmd_start,
   input  wire logic fb_stuck,
   // Field lines
   output logic      input_closed,
   output logic      start_closed,
   output logic      relay_fb
);
   logic [1:0] lag;         // Contact travel delay
   // Contacts are plain levels, always driven by the switches
   assign input_closed = cmd_input;
   assign start_closed = cmd_start;
   // Feedback follows drive; stuck open models a dead relay coil
   always_ff @(posedge aclk) begin
      lag <= {lag[0], safety_out};
   end
   assign relay_fb = fb_stuck ? 1'b0 : lag[1];
endmodule // field_side_model
`default_nettype wire

// [dv/safety_relay_start_control_tb.sv]
// Purpose: Self-checking bench of the safety relay start controller
// Assumes: Short counts WAIT 20, PULSE 5, RELAY 8 cycles
// Notes:   Each power cycle is a reset with a fresh selector setting
`timescale 1ns/100ps
`include "safety_relay_consts.svh"
`default_nettype none
module safety_relay_start_control_tb;
   import safety_relay_pkg::*;
   logic aclk, aresetn, efi, efs, cmd_input, cmd_start, fb_stuck;
   logic input_closed, start_closed, relay_fb, safety_out, aux_nc_out, ready, fault, irq;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs;
   mode_t       mode_sel;
   int          n_errors, cmp_count;
   // Design with shortened counts
   safety_relay_start_control #(.WAIT_CYC(20), .PULSE_CYC(5), .RELAY_CYC(8))
      safety_relay_start_control_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
      .input_closed(input_closed), .start_closed(start_closed), .earth_fault_input(efi),
      .earth_fault_start(efs), .mode_sel(mode_sel), .relay_fb(relay_fb),
      .safety_out(safety_out), .aux_nc_out(aux_nc_out), .ready(ready), .fault(fault),
      .irq(irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   // Field switches and relay feedback
   field_side_model field_side_model_i (.aclk(aclk), .safety_out(safety_out),
      .cmd_input(cmd_input), .cmd_start(cmd_start), .fb_stuck(fb_stuck),
      .input_closed(input_closed), .start_closed(start_closed), .relay_fb(relay_fb));
   // 20 MHz clock
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Verdict in one place
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Register write; both channels offered together, bready held till bvalid
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            r = bresp;
            break;
         end
      end
   endtask
   // Register read
   task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            d = rdata;
            r = rresp;
            break;
         end
      end
   endtask
   // Power cycle; selector is set while reset is held
   task automatic power(input mode_t m);
      mode_sel <= m;
      {efi, efs, cmd_input, cmd_start, fb_stuck} <= 5'h00;
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
   endtask
   // Output and its auxiliary contact together
   task automatic out_is(input logic e);
      chk("safety_out", {31'h0, e}, {31'h0, safety_out});
      chk("aux_nc_out", {31'h0, ~e}, {31'h0, aux_nc_out});
   endtask
   // Time-zero values
   initial begin
      {aresetn, efi, efs, cmd_input, cmd_start, fb_stuck} = 6'h00;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hf;
      mode_sel = `MODE_AUTO;
   end
   // Main sequence
   initial begin
      n_errors = 0;
      cmp_count = 0;
      @(posedge aclk);
      power(`MODE_AUTO);
      rdr(`REG_IRQ_MASK, rd, rs);
      chk("mask reset", 32'h0, rd);
      rdr(8'h10, rd, rs);
      chk("unmapped resp", 32'(`RESP_SLVERR), 32'(rs));
      wr(`REG_STATUS, 32'hffff_ffff, rs);
      chk("ro write resp", 32'(`RESP_OKAY), 32'(rs));
      rdr(`REG_STATUS, rd, rs);
      chk("latched mode", 32'(`MODE_AUTO), 32'(rd[5:3]));
      wr(`REG_IRQ_MASK, 32'h1 << `IRQ_OUT_ON, rs);
      cmd_input <= 1'b1;
      repeat (2) @(posedge aclk);
      out_is(1'b1);
      repeat (2) @(posedge aclk);
      chk("irq on", 32'h1, {31'h0, irq});
      chk("ready", 32'h1, {31'h0, ready});
      wr(`REG_CTRL, 32'h1, rs);
      repeat (2) @(posedge aclk);
      out_is(1'b0);
      rdr(`REG_CTRL, rd, rs);
      chk("soft stop", 32'h1, rd);
      wr(`REG_CTRL, 32'h0, rs);
      repeat (2) @(posedge aclk);
      out_is(1'b1);
      wr(`REG_IRQ_MASK, 32'h0, rs);
      repeat (2) @(posedge aclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(`REG_IRQ_STATUS, 32'h1 << `IRQ_OUT_ON, rs);
      rdr(`REG_IRQ_STATUS, rd, rs);
      chk("flag cleared", 32'h0, {31'h0, rd[`IRQ_OUT_ON]});
      chk("off flag", 32'h1, {31'h0, rd[`IRQ_OUT_OFF]});
      cmd_input <= 1'b0;
      repeat (2) @(posedge aclk);
      out_is(1'b0);
      // Manual start
      power(`MODE_MANUAL);
      cmd_input <= 1'b1;
      repeat (4) @(posedge aclk);
      out_is(1'b0);
      cmd_start <= 1'b1;
      repeat (2) @(posedge aclk);
      out_is(1'b1);
      // Falling edge, input first, short pulse refused
      power(`MODE_FALL);
      cmd_input <= 1'b1;
      cmd_start <= 1'b1;
      repeat (2) @(posedge aclk);
      cmd_start <= 1'b0;
      repeat (3) @(posedge aclk);
      out_is(1'b0);
      cmd_start <= 1'b1;
      repeat (8) @(posedge aclk);
      out_is(1'b0);
      cmd_start <= 1'b0;
      repeat (3) @(posedge aclk);
      out_is(1'b1);
      // Falling edge, start first
      power(`MODE_FALL);
      cmd_start <= 1'b1;
      repeat (8) @(posedge aclk);
      cmd_input <= 1'b1;
      repeat (2) @(posedge aclk);
      cmd_start <= 1'b0;
      repeat (3) @(posedge aclk);
      out_is(1'b1);
      // Rising edge with waiting period
      power(`MODE_RISE);
      cmd_input <= 1'b1;
      cmd_start <= 1'b1;
      repeat (30) @(posedge aclk);
      out_is(1'b0);
      cmd_start <= 1'b0;
      repeat (2) @(posedge aclk);
      cmd_start <= 1'b1;
      repeat (2) @(posedge aclk);
      cmd_start <= 1'b0;
      repeat (3) @(posedge aclk);
      out_is(1'b0);
      cmd_start <= 1'b1;
      repeat (8) @(posedge aclk);
      out_is(1'b1);
      // Selector moved while running: latched until power cycle
      power(`MODE_AUTO);
      cmd_input <= 1'b1;
      repeat (3) @(posedge aclk);
      mode_sel <= `MODE_MANUAL;
      repeat (3) @(posedge aclk);
      chk("fault", 32'h1, {31'h0, fault});
      out_is(1'b0);
      cmd_input <= 1'b0;
      mode_sel <= `MODE_AUTO;
      repeat (2) @(posedge aclk);
      cmd_input <= 1'b1;
      repeat (4) @(posedge aclk);
      out_is(1'b0);
      chk("ready", 32'h0, {31'h0, ready});
      rdr(`REG_IRQ_STATUS, rd, rs);
      chk("change flag", 32'h1, {31'h0, rd[`IRQ_SEL_CHANGE]});
      // Neutral and forbidden positions
      for (int m = 0; m < 8; m = m + 5) begin
         power(mode_t'(m));
         cmd_input <= 1'b1;
         repeat (3) @(posedge aclk);
         chk("sel fault", 32'h1, {31'h0, fault});
         out_is(1'b0);
         rdr(`REG_IRQ_STATUS, rd, rs);
         chk("sel flag", 32'h1, {31'h0, rd[`IRQ_NEUTRAL + m / 5]});
      end
      // Earth faults on both circuits
      for (int k = 0; k < 2; k++) begin
         power(`MODE_AUTO);
         if (k == 0) efi <= 1'b1;
         else efs <= 1'b1;
         repeat (3) @(posedge aclk);
         chk("earth fault", 32'h1, {31'h0, fault});
         rdr(`REG_IRQ_STATUS, rd, rs);
         chk("earth flag", 32'h1, {31'h0, rd[`IRQ_EARTH]});
      end
      // Relay that never closes
      power(`MODE_AUTO);
      fb_stuck <= 1'b1;
      cmd_input <= 1'b1;
      repeat (14) @(posedge aclk);
      chk("relay fault", 32'h1, {31'h0, fault});
      out_is(1'b0);
      rdr(`REG_IRQ_STATUS, rd, rs);
      chk("relay flag", 32'h1, {31'h0, rd[`IRQ_RELAY]});
      close_out();
   end
   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      close_out();
   end
endmodule // safety_relay_start_control_tb
`default_nettype wire
